/* File: common/tsc_pkg.sv */
// link constants, types and crc
`default_nettype none
package tsc_pkg;
  // timing
  localparam int CLK_PERIOD_NS     = 8;
  localparam int LINK_PERIOD_NS    = 64;
  localparam int LINK_HALF_CYC     = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int STARTUP_CYC       = 16;
  localparam int TTF_WINDOW_EDGES  = 32;
  localparam int RSP_TIMEOUT_EDGES = 96;
  // page offsets
  localparam logic [2:0] PG_SERIAL     = 3'h0;
  localparam logic [2:0] PG_CONFIG     = 3'h1;
  localparam logic [2:0] PG_KEY_HIGH_PASSWORD_LOW_PAGE  = 3'h2;
  localparam logic [2:0] PG_KEY_LOW_BYTES       = 3'h3;
  localparam logic [2:0] PG_USER_PLAIN = 3'h2;
  localparam logic [2:0] PG_USER_AUTH  = 3'h4;
  localparam logic [2:0] PG_LAST       = 3'h5;
  localparam logic [31:0] PG_RESET     = 32'h0000_0000;
  // config_byte_0 and config_byte_2 fields
  localparam int CFG_AUTH_BIT = 0;
  localparam int CFG_LOCK_BIT = 1;
  localparam int CFG_TTF_BIT  = 2;
  localparam int TTF_LEN_LSB  = 0;
  localparam int TTF_AC_BIT   = 2;
  localparam int TTF_HALF_BIT = 3;
  // command headers and frame lengths
  localparam logic [2:0] CMD_REQ_HDR = 3'h1;
  localparam logic [4:0] CMD_SEL     = 5'h00;
  localparam logic [4:0] CMD_SIL     = 5'h01;
  localparam logic [4:0] CMD_QUIET   = 5'h0E;
  localparam logic [6:0] LEN_REQ     = 7'h05;
  localparam logic [6:0] LEN_AC_BASE = 7'h0D;
  localparam logic [6:0] LEN_SEL     = 7'h2D;
  localparam logic [6:0] LEN_QUIET   = 7'h0D;
  localparam logic [6:0] LEN_CHAL    = 7'h40;
  localparam logic [6:0] LEN_MAX     = 7'h48;
  localparam logic [1:0] ACK_BITS    = 2'h1;
  localparam logic [7:0] CRC_POLY    = 8'h1D;
  localparam logic [7:0] CRC_INIT    = 8'hFF;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_READY = 3'b001,
    ST_INIT  = 3'b010,
    ST_AUTH  = 3'b011,
    ST_SEL   = 3'b100,
    ST_QUIET = 3'b101,
    ST_TTF   = 3'b110
  } tsc_state_e;

  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8
endpackage : tsc_pkg
`default_nettype wire

/* File: common/tsc_link_if.sv */
// link between reader end and tag end
`timescale 1ns/100ps
`default_nettype none
interface tsc_link_if;
  logic field_on;
  logic lk_clk;
  logic dn_bit;
  logic dn_frm;
  logic up_bit;
  logic up_frm;
  logic up_ac;
  modport tag (input field_on, lk_clk, dn_bit, dn_frm, output up_bit, up_frm, up_ac);
  modport reader (output field_on, lk_clk, dn_bit, dn_frm, input up_bit, up_frm, up_ac);
endinterface : tsc_link_if
`default_nettype wire

/* File: hdl/tsc_buf2.sv */
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module tsc_buf2 #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  initial if (W < 1) $error("W must be positive");

  logic [W-1:0] d0_ff, d1_ff;
  logic [1:0]   cnt_ff;
  wire          push = in_valid_i & in_ready_o;
  wire          pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o  = d0_ff;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d0_ff  <= '0;
      d1_ff  <= '0;
      cnt_ff <= 2'h0;
    end else begin
      if (pop) begin
        d0_ff <= (cnt_ff == 2'h2) ? d1_ff : in_data_i;
      end else if (push && cnt_ff == 2'h0) begin
        d0_ff <= in_data_i;
      end
      if (push && (cnt_ff - {1'b0, pop}) == 2'h1) begin
        d1_ff <= in_data_i;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : tsc_buf2
`default_nettype wire

/* File: hdl/tsc_rdr_end.sv */
// reader end: field, link clock, command and answer paths
`timescale 1ns/100ps
`default_nettype none
module tsc_rdr_end #(
  parameter int HALF_CYC = tsc_pkg::LINK_HALF_CYC
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // link
  tsc_link_if.reader       lk,
  // user command side
  input  wire logic        field_en_i,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [6:0]  cmd_len_i,
  input  wire logic [71:0] cmd_bits_i,
  // user response side
  output logic             rsp_valid_o,
  input  wire logic        rsp_ready_i,
  output logic [39:0]      rsp_data_o,
  output logic [5:0]       rsp_len_o,
  output logic             rsp_ac_o,
  output logic             rsp_auth_o
);
  initial if (HALF_CYC < 4 || HALF_CYC > 255) $error("HALF_CYC out of range");

  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_SEND = 2'b01,
    RS_RECV = 2'b10
  } tsc_rstate_e;

  tsc_rstate_e st_ff;
  logic [7:0]  div_ff;
  logic        lk_ff, field_ff, dn_bit_ff, dn_frm_ff;
  logic [71:0] tx_sr_ff;
  logic [6:0]  tx_left_ff;
  logic [40:0] rx_sr_ff;
  logic [5:0]  rx_cnt_ff;
  logic        got_ff, ac_ff;
  logic [6:0]  tout_ff;
  logic        ub_s1_ff, ub_s2_ff, uf_s1_ff, uf_s2_ff, ua_s1_ff, ua_s2_ff;
  logic        buf_ready;
  logic [47:0] buf_out;

  wire half_end = field_ff & (div_ff == 8'(HALF_CYC - 1));
  wire rise_en  = half_end & ~lk_ff;
  wire fall_en  = half_end & lk_ff;
  wire accept   = cmd_valid_i & cmd_ready_o;
  wire rx_done  = (st_ff == RS_RECV) & rise_en & ~uf_s2_ff & got_ff;
  wire tout_end = (st_ff == RS_RECV) & rise_en & ~uf_s2_ff & ~got_ff
                  & (tout_ff == 7'(tsc_pkg::RSP_TIMEOUT_EDGES - 1));
  wire [5:0] rx_len = rx_cnt_ff - 6'h01;
  // auth bit of config_byte_0 in a select answer
  wire rx_auth = (rx_len == 6'h28) & rx_sr_ff[32 + tsc_pkg::CFG_AUTH_BIT];

  assign cmd_ready_o = (st_ff == RS_IDLE) & buf_ready & field_ff;
  assign lk.field_on = field_ff;
  assign lk.lk_clk   = lk_ff;
  assign lk.dn_bit   = dn_bit_ff;
  assign lk.dn_frm   = dn_frm_ff;
  assign {rsp_auth_o, rsp_ac_o, rsp_len_o, rsp_data_o} = buf_out;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {ub_s1_ff, ub_s2_ff, uf_s1_ff, uf_s2_ff, ua_s1_ff, ua_s2_ff} <= 6'h00;
      field_ff <= 1'b0;
      div_ff   <= 8'h00;
      lk_ff    <= 1'b0;
    end else begin
      {ub_s1_ff, ub_s2_ff} <= {lk.up_bit, ub_s1_ff};
      {uf_s1_ff, uf_s2_ff} <= {lk.up_frm, uf_s1_ff};
      {ua_s1_ff, ua_s2_ff} <= {lk.up_ac, ua_s1_ff};
      field_ff <= field_en_i;
      div_ff   <= (!field_ff || half_end) ? 8'h00 : div_ff + 8'h01;
      lk_ff    <= field_ff & (lk_ff ^ half_end);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff      <= RS_IDLE;
      dn_bit_ff  <= 1'b0;
      dn_frm_ff  <= 1'b0;
      tx_sr_ff   <= '0;
      tx_left_ff <= 7'h00;
      rx_sr_ff   <= '0;
      rx_cnt_ff  <= 6'h00;
      got_ff     <= 1'b0;
      ac_ff      <= 1'b0;
      tout_ff    <= 7'h00;
    end else if (!field_ff) begin
      st_ff     <= RS_IDLE;
      dn_frm_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        RS_IDLE: if (accept) begin
          // k and challenge words come from the user
          tx_sr_ff   <= cmd_bits_i;
          tx_left_ff <= cmd_len_i;
          st_ff      <= RS_SEND;
        end
        RS_SEND: if (fall_en) begin
          if (tx_left_ff != 7'h00) begin
            dn_bit_ff  <= tx_sr_ff[71];
            dn_frm_ff  <= 1'b1;
            tx_sr_ff   <= {tx_sr_ff[70:0], 1'b0};
            tx_left_ff <= tx_left_ff - 7'h01;
          end else begin
            dn_frm_ff <= 1'b0;
            rx_cnt_ff <= 6'h00;
            got_ff    <= 1'b0;
            tout_ff   <= 7'h00;
            st_ff     <= RS_RECV;
          end
        end
        RS_RECV: if (rise_en) begin
          if (uf_s2_ff) begin
            rx_sr_ff  <= {rx_sr_ff[39:0], ub_s2_ff};
            rx_cnt_ff <= (rx_cnt_ff == 6'h29) ? rx_cnt_ff : rx_cnt_ff + 6'h01;
            got_ff    <= 1'b1;
            ac_ff     <= ua_s2_ff;
          end else if (got_ff || tout_end) begin
            st_ff <= RS_IDLE;
          end else begin
            tout_ff <= tout_ff + 7'h01;
          end
        end
        default: st_ff <= RS_IDLE;
      endcase
    end
  end

  // a full buffer blocks commands, so no answer is lost
  tsc_buf2 #(.W(48)) u_buf (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (rx_done),
    .in_ready_o  (buf_ready),
    .in_data_i   ({rx_auth, ac_ff, rx_len, rx_sr_ff[39:0]}),
    .out_valid_o (rsp_valid_o),
    .out_ready_i (rsp_ready_i),
    .out_data_o  (buf_out)
  );
endmodule : tsc_rdr_end
`default_nettype wire

/* File: hdl/tsc_tag_end.sv */
// tag end: protocol states, command decode and answers
// Notes on behaviour
// - field loss drops to power off anywhere
// - after start-up wait in ready
// - first request enters init; later change mode
// - auth select enters authenticate; challenge selects
// - plain select goes straight to selected
// - selected state transfers are unencrypted
// - silence commands enter quiet until field off
// - tag-first: window expiry starts continuous send
// - reader finds first collision position k
// - matching tags send remaining 32-k bits
// - reader repeats until one serial resolved
// - collision answer uses anticollision coding
// - select answer: config bytes, high byte, crc
// - page 1 top byte: reserved or password
// - auth and locked: high byte sent ones
// - reader checks auth bit, starts challenge
// - reader sends 32-bit random, 32-bit secret
// - matching secret: 32-bit encrypted answer
// - challenge answer uses manchester coding
// - plain map: serial, config, user from 2
// - auth map: keys/password, user from 4
`timescale 1ns/100ps
`default_nettype none
module tsc_tag_end (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // link
  tsc_link_if.tag          lk,
  // page load port
  input  wire logic        pg_we_i,
  input  wire logic [2:0]  pg_addr_i,
  input  wire logic [31:0] pg_data_i,
  // status
  output logic [2:0]       state_o,
  output logic [1:0]       resp_mode_o
);
  tsc_pkg::tsc_state_e state_ff, nxt_state;
  logic [31:0] pg_ff [0:5];
  logic        fld_s1_ff, fld_s2_ff, lk_s1_ff, lk_s2_ff, lk_s3_ff;
  logic        dn_s1_ff, dn_s2_ff, frm_s1_ff, frm_s2_ff, frm_s3_ff;
  logic [71:0] rx_sr_ff;
  logic [6:0]  rx_cnt_ff;
  logic [40:0] tx_sr_ff;
  logic [5:0]  tx_left_ff;
  logic        up_bit_ff, up_frm_ff, up_ac_ff, tog_ff;
  logic [1:0]  mode_ff, nxt_mode, ttf_idx_ff;
  logic [4:0]  up_cnt_ff;
  logic [5:0]  win_ff;
  logic        ld, ld_ac;
  logic [39:0] ld_word;
  logic [5:0]  ld_len;

  ////////////////////////////////////////////////////////////////////////////
  // page fields
  wire [31:0] pg_ser   = pg_ff[tsc_pkg::PG_SERIAL];
  wire [31:0] pg_cfg   = pg_ff[tsc_pkg::PG_CONFIG];
  wire [31:0] pg_kh_pl = pg_ff[tsc_pkg::PG_KEY_HIGH_PASSWORD_LOW_PAGE];
  wire [31:0] pg_kl    = pg_ff[tsc_pkg::PG_KEY_LOW_BYTES];
  wire [7:0]  cfg0     = pg_cfg[7:0];
  wire [7:0]  cfg1     = pg_cfg[15:8];
  wire [7:0]  cfg2     = pg_cfg[23:16];
  wire [7:0]  pwh      = pg_cfg[31:24];
  wire        auth_on  = cfg0[tsc_pkg::CFG_AUTH_BIT];
  wire        locked   = cfg0[tsc_pkg::CFG_LOCK_BIT];
  wire        ttf_on   = cfg0[tsc_pkg::CFG_TTF_BIT];
  // byte 0 first, each byte msb first
  wire [31:0] ser_tx   = {pg_ser[7:0], pg_ser[15:8], pg_ser[23:16], pg_ser[31:24]};
  wire [7:0]  pwh_tx   = (auth_on & locked) ? 8'hFF : pwh;
  wire [31:0] sel_word = {cfg0, cfg1, cfg2, pwh_tx};
  wire [2:0]  user_pg  = auth_on ? tsc_pkg::PG_USER_AUTH : tsc_pkg::PG_USER_PLAIN;
  wire [2:0]  ttf_pg   = user_pg + {1'b0, ttf_idx_ff};
  wire [31:0] ttf_word = (ttf_pg <= tsc_pkg::PG_LAST) ? pg_ff[ttf_pg] : 32'h0000_0000;
  wire [1:0]  ttf_last = cfg2[tsc_pkg::TTF_LEN_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // received frame decode
  wire        field_ok = fld_s2_ff;
  wire        rise     = lk_s2_ff & ~lk_s3_ff;
  wire        tx_idle  = (tx_left_ff == 6'h00) & ~up_frm_ff;
  wire        cmd_end  = frm_s3_ff & ~frm_s2_ff & tx_idle;
  wire [71:0] aligned  = rx_sr_ff << (7'h48 - rx_cnt_ff);
  wire [4:0]  hdr      = aligned[71:67];
  wire [31:0] body     = aligned[66:35];
  wire [31:0] rnd      = aligned[71:40];
  wire [31:0] secret   = aligned[39:8];
  wire [31:0] ac_mask  = ~(32'hFFFF_FFFF >> hdr);
  wire        ser_hit  = (body == ser_tx);
  wire dec_req   = (rx_cnt_ff == tsc_pkg::LEN_REQ) & (hdr[4:2] == tsc_pkg::CMD_REQ_HDR);
  wire dec_sel   = (rx_cnt_ff == tsc_pkg::LEN_SEL) & (hdr == tsc_pkg::CMD_SEL) & ser_hit;
  wire dec_sil   = (rx_cnt_ff == tsc_pkg::LEN_SEL) & (hdr == tsc_pkg::CMD_SIL) & ser_hit;
  wire dec_quiet = (rx_cnt_ff == tsc_pkg::LEN_QUIET) & (hdr == tsc_pkg::CMD_QUIET);
  wire dec_ac    = (rx_cnt_ff == tsc_pkg::LEN_AC_BASE + {2'b00, hdr})
                   & (((body ^ ser_tx) & ac_mask) == 32'h0000_0000);
  // cipher stand-in: the reader user must match it
  wire dec_chal  = (rx_cnt_ff == tsc_pkg::LEN_CHAL) & (secret == (rnd ^ pg_kl));
  wire [31:0] chal_word = {cfg2, pwh, pg_kh_pl[7:0], pg_kh_pl[15:8]} ^ rnd ^ pg_kh_pl;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    nxt_mode  = mode_ff;
    ld        = 1'b0;
    ld_word   = 40'h00_0000_0000;
    ld_len    = 6'h00;
    ld_ac     = 1'b0;
    unique case (state_ff)
      tsc_pkg::ST_OFF: begin
        if (up_cnt_ff == 5'(tsc_pkg::STARTUP_CYC - 1)) nxt_state = tsc_pkg::ST_READY;
      end
      tsc_pkg::ST_READY, tsc_pkg::ST_TTF, tsc_pkg::ST_INIT: begin
        if (cmd_end && dec_req) begin
          nxt_state = tsc_pkg::ST_INIT;
          nxt_mode  = hdr[1:0];
          ld        = 1'b1;
          ld_word   = {ser_tx, 8'h00};
          ld_len    = 6'h20;
        end else if (state_ff == tsc_pkg::ST_INIT && cmd_end && dec_sil) begin
          nxt_state = tsc_pkg::ST_QUIET;
          ld        = 1'b1;
          ld_word   = {tsc_pkg::ACK_BITS, 38'h0};
          ld_len    = 6'h02;
        end else if (state_ff == tsc_pkg::ST_INIT && cmd_end && dec_sel) begin
          nxt_state = auth_on ? tsc_pkg::ST_AUTH : tsc_pkg::ST_SEL;
          ld        = 1'b1;
          ld_word   = {sel_word, tsc_pkg::crc8(sel_word)};
          ld_len    = 6'h28;
        end else if (state_ff == tsc_pkg::ST_INIT && cmd_end && dec_ac) begin
          ld        = 1'b1;
          ld_word   = {ser_tx << hdr, 8'h00};
          ld_len    = 6'h20 - {1'b0, hdr};
          ld_ac     = 1'b1;
        end else if (state_ff == tsc_pkg::ST_READY && ttf_on
                     && win_ff == 6'(tsc_pkg::TTF_WINDOW_EDGES)) begin
          nxt_state = tsc_pkg::ST_TTF;
        end else if (state_ff == tsc_pkg::ST_TTF && tx_idle) begin
          ld        = 1'b1;
          ld_word   = {ttf_word, 8'h00};
          ld_len    = 6'h20;
          ld_ac     = cfg2[tsc_pkg::TTF_AC_BIT];
        end
      end
      tsc_pkg::ST_AUTH: begin
        if (cmd_end && dec_chal) begin
          nxt_state = tsc_pkg::ST_SEL;
          ld        = 1'b1;
          ld_word   = {chal_word, tsc_pkg::crc8(chal_word)};
          ld_len    = 6'h28;
        end
      end
      // page access lives outside this block
      tsc_pkg::ST_SEL: begin
        if (cmd_end && dec_quiet) nxt_state = tsc_pkg::ST_QUIET;
      end
      tsc_pkg::ST_QUIET: nxt_state = state_ff;
      default: nxt_state = tsc_pkg::ST_OFF;
    endcase
    if (!field_ok) begin
      nxt_state = tsc_pkg::ST_OFF;
      ld        = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {fld_s1_ff, fld_s2_ff, lk_s1_ff, lk_s2_ff, lk_s3_ff} <= 5'h00;
      {dn_s1_ff, dn_s2_ff, frm_s1_ff, frm_s2_ff, frm_s3_ff} <= 5'h00;
    end else begin
      {fld_s1_ff, fld_s2_ff}            <= {lk.field_on, fld_s1_ff};
      {lk_s1_ff, lk_s2_ff, lk_s3_ff}    <= {lk.lk_clk, lk_s1_ff, lk_s2_ff};
      {dn_s1_ff, dn_s2_ff}              <= {lk.dn_bit, dn_s1_ff};
      {frm_s1_ff, frm_s2_ff, frm_s3_ff} <= {lk.dn_frm, frm_s1_ff, frm_s2_ff};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 6; i++) pg_ff[i] <= tsc_pkg::PG_RESET;
    end else if (pg_we_i && pg_addr_i <= tsc_pkg::PG_LAST) begin
      pg_ff[pg_addr_i] <= pg_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff   <= tsc_pkg::ST_OFF;
      mode_ff    <= 2'h0;
      up_cnt_ff  <= 5'h00;
      win_ff     <= 6'h00;
      ttf_idx_ff <= 2'h0;
      rx_sr_ff   <= '0;
      rx_cnt_ff  <= 7'h00;
    end else begin
      state_ff  <= nxt_state;
      mode_ff   <= field_ok ? nxt_mode : 2'h0;
      up_cnt_ff <= (state_ff == tsc_pkg::ST_OFF && field_ok) ? up_cnt_ff + 5'h01 : 5'h00;
      if (state_ff != tsc_pkg::ST_READY) win_ff <= 6'h00;
      else if (rise && win_ff != 6'(tsc_pkg::TTF_WINDOW_EDGES)) win_ff <= win_ff + 6'h01;
      if (state_ff != tsc_pkg::ST_TTF) ttf_idx_ff <= 2'h0;
      else if (ld) ttf_idx_ff <= (ttf_idx_ff == ttf_last) ? 2'h0 : ttf_idx_ff + 2'h1;
      if (frm_s3_ff && !frm_s2_ff) begin
        rx_cnt_ff <= 7'h00;
      end else if (rise && frm_s2_ff) begin
        rx_sr_ff  <= {rx_sr_ff[70:0], dn_s2_ff};
        rx_cnt_ff <= (rx_cnt_ff == tsc_pkg::LEN_MAX) ? rx_cnt_ff : rx_cnt_ff + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half rate only in the tag-first stream
  wire half = (state_ff == tsc_pkg::ST_TTF) & cfg2[tsc_pkg::TTF_HALF_BIT];
  wire tick = rise & (~half | tog_ff);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sr_ff   <= '0;
      tx_left_ff <= 6'h00;
      up_bit_ff  <= 1'b0;
      up_frm_ff  <= 1'b0;
      up_ac_ff   <= 1'b0;
      tog_ff     <= 1'b0;
    end else if (!field_ok) begin
      tx_left_ff <= 6'h00;
      up_frm_ff  <= 1'b0;
      up_bit_ff  <= 1'b0;
    end else begin
      if (rise) tog_ff <= ~tog_ff;
      if (ld) begin
        tx_sr_ff   <= {1'b1, ld_word};
        tx_left_ff <= ld_len + 6'h01;
        up_ac_ff   <= ld_ac;
      end else if (tick) begin
        if (tx_left_ff != 6'h00) begin
          up_bit_ff  <= tx_sr_ff[40];
          up_frm_ff  <= 1'b1;
          tx_sr_ff   <= {tx_sr_ff[39:0], 1'b0};
          tx_left_ff <= tx_left_ff - 6'h01;
        end else begin
          up_frm_ff <= 1'b0;
          up_bit_ff <= 1'b0;
        end
      end
    end
  end

  assign lk.up_bit   = up_bit_ff;
  assign lk.up_frm   = up_frm_ff;
  assign lk.up_ac    = up_ac_ff;
  assign state_o     = state_ff;
  assign resp_mode_o = mode_ff;
endmodule : tsc_tag_end
`default_nettype wire

/* File: dv/tsc_link_monitor.sv */
// wire-level checks on the reader/tag link
`timescale 1ns/100ps
`default_nettype none
module tsc_link_monitor (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // link wires
  input wire logic field_on,
  input wire logic lk_clk,
  input wire logic dn_bit,
  input wire logic dn_frm,
  input wire logic up_bit,
  input wire logic up_frm,
  input wire logic up_ac
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////
  // four cycles high at the default divider
  sequence s_lk_high;
    (lk_clk || !field_on) [*4] ##1 !lk_clk;
  endsequence
  // lets the registered field flag settle
  sequence s_field_gone;
    !field_on [*3];
  endsequence
  property p_lk_half;
    $rose(lk_clk) |-> s_lk_high;
  endproperty
  property p_lk_idle;
    s_field_gone |-> !lk_clk;
  endproperty
  property p_dn_idle;
    s_field_gone |-> !dn_frm;
  endproperty
  property p_dn_edge;
    $changed(dn_bit) && dn_frm |-> !lk_clk;
  endproperty
  property p_up_sof;
    $rose(up_frm) |-> up_bit;
  endproperty
  property p_up_ac;
    up_frm && $past(up_frm) |-> $stable(up_ac);
  endproperty
  property p_up_edge;
    $changed(up_bit) && up_frm && $past(up_frm) |-> lk_clk || $past(lk_clk);
  endproperty
  property p_field_drop;
    $fell(field_on) |-> ##8 (!up_frm) [*4];
  endproperty
  a_lk_half: assert property (p_lk_half) else $error("lk_clk high phase wrong");
  a_lk_idle: assert property (p_lk_idle) else $error("lk_clk without field");
  a_dn_idle: assert property (p_dn_idle) else $error("dn_frm without field");
  a_dn_edge: assert property (p_dn_edge) else $error("dn_bit moved, clock high");
  a_up_sof: assert property (p_up_sof) else $error("no start bit");
  a_up_ac: assert property (p_up_ac) else $error("up_ac moved in frame");
  a_up_edge: assert property (p_up_edge) else $error("up_bit moved, clock low");
  a_field_drop: assert property (p_field_drop) else $error("answer after field loss");
endmodule : tsc_link_monitor
`default_nettype wire

/* File: dv/test_rfid_tag_state_and_command_logic.sv */
// bench: both ends joined over one link
`timescale 1ns/100ps
`default_nettype none
module test_rfid_tag_state_and_command_logic;
  localparam logic [31:0] SER_PG = 32'h4D3C_2B1A;
  localparam logic [31:0] SER_W  = {SER_PG[7:0], SER_PG[15:8], SER_PG[23:16], SER_PG[31:24]};
  localparam logic [31:0] KP2    = 32'h9988_7766;
  localparam logic [31:0] KP3    = 32'h1357_2468;
  localparam logic [31:0] RND    = 32'h6B2F_91D4;
  localparam logic [39:0] M32    = 40'h00_FFFF_FFFF;
  localparam logic [39:0] MHI    = 40'hFF_FFFF_FF00;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        field_en  = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [6:0]  cmd_len   = 7'h00;
  logic [71:0] cmd_bits  = 72'h0;
  logic        rsp_ready = 1'b0;
  logic        pg_we     = 1'b0;
  logic [2:0]  pg_addr   = 3'h0;
  logic [31:0] pg_data   = 32'h0;
  logic        cmd_ready, rsp_valid, rsp_ac, rsp_auth;
  logic [39:0] rsp_data;
  logic [5:0]  rsp_len;
  logic [2:0]  state;
  logic [1:0]  mode;
  int          err_count  = 0;
  int          num_checks = 0;
  always #(tsc_pkg::CLK_PERIOD_NS / 2) sys_clk_i = ~sys_clk_i;
  tsc_link_if lk_if ();
  tsc_rdr_end tsc_rdr_end_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .lk(lk_if), .field_en_i(field_en),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_len_i(cmd_len), .cmd_bits_i(cmd_bits),
    .rsp_valid_o(rsp_valid), .rsp_ready_i(rsp_ready), .rsp_data_o(rsp_data), .rsp_len_o(rsp_len),
    .rsp_ac_o(rsp_ac), .rsp_auth_o(rsp_auth));
  tsc_tag_end tsc_tag_end_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .lk(lk_if), .pg_we_i(pg_we),
    .pg_addr_i(pg_addr), .pg_data_i(pg_data), .state_o(state), .resp_mode_o(mode));
  tsc_link_monitor tsc_link_monitor_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .field_on(lk_if.field_on),
    .lk_clk(lk_if.lk_clk), .dn_bit(lk_if.dn_bit), .dn_frm(lk_if.dn_frm), .up_bit(lk_if.up_bit),
    .up_frm(lk_if.up_frm), .up_ac(lk_if.up_ac));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_st(input tsc_pkg::tsc_state_e exp);
    @(negedge sys_clk_i);
    for (int n = 0; n < 1000 && state !== exp; n++) @(negedge sys_clk_i);
    chk({37'h0, state}, {37'h0, exp});
    @(posedge sys_clk_i);
  endtask : wait_st
  task automatic pg_wr(input logic [2:0] a, input logic [31:0] d);
    pg_we   <= 1'b1;
    pg_addr <= a;
    pg_data <= d;
    @(posedge sys_clk_i);
    pg_we   <= 1'b0;
    @(posedge sys_clk_i);
  endtask : pg_wr
  task automatic send(input logic [6:0] len, input logic [71:0] bits);
    cmd_len   <= len;
    cmd_bits  <= bits;
    cmd_valid <= 1'b1;
    @(negedge sys_clk_i);
    for (int n = 0; n < 3000 && cmd_ready !== 1'b1; n++) @(negedge sys_clk_i);
    @(posedge sys_clk_i);
    cmd_valid <= 1'b0;
    @(posedge sys_clk_i);
  endtask : send
  // len 0: no answer allowed
  task automatic expect_rsp(input logic [5:0] len, input logic [39:0] dat, input logic [39:0] msk,
                            input logic [1:0] fl);
    rsp_ready <= 1'b1;
    @(negedge sys_clk_i);
    for (int n = 0; n < 1500 && rsp_valid !== 1'b1; n++) @(negedge sys_clk_i);
    chk({39'h0, rsp_valid}, {39'h0, len != 6'h00});
    if (len != 6'h00) begin
      chk(rsp_data & msk, dat & msk);
      chk({34'h0, rsp_len}, {34'h0, len});
      chk({38'h0, rsp_auth, rsp_ac}, {38'h0, fl});
    end
    @(posedge sys_clk_i);
    rsp_ready <= 1'b0;
    @(posedge sys_clk_i);
  endtask : expect_rsp
  task automatic xfer(input logic [6:0] cl, input logic [71:0] cb, input logic [5:0] len,
                      input logic [39:0] dat, input logic [39:0] msk, input logic [1:0] fl);
    send(cl, cb);
    expect_rsp(len, dat, msk, fl);
  endtask : xfer
  ////////////////////////////////////////////////////////////////
  task automatic t_plain();
    pg_wr(tsc_pkg::PG_SERIAL, SER_PG);
    pg_wr(tsc_pkg::PG_CONFIG, 32'h3C00_2200);
    field_en <= 1'b1;
    wait_st(tsc_pkg::ST_READY);
    // stalled receiver: two answers fill the buffer
    send(tsc_pkg::LEN_REQ, {tsc_pkg::CMD_REQ_HDR, 2'h1, 67'h0});
    send(tsc_pkg::LEN_REQ, {tsc_pkg::CMD_REQ_HDR, 2'h2, 67'h0});
    repeat (1500) @(negedge sys_clk_i);
    chk({39'h0, cmd_ready}, 40'h0);
    @(posedge sys_clk_i);
    expect_rsp(6'h20, {8'h00, SER_W}, M32, 2'h0);
    expect_rsp(6'h20, {8'h00, SER_W}, M32, 2'h0);
    chk({38'h0, mode}, 40'h2);
    wait_st(tsc_pkg::ST_INIT);
    xfer(tsc_pkg::LEN_AC_BASE + 7'h08, {5'h08, SER_W[31:24], 8'h00, 51'h0}, 6'h18, {16'h0, SER_W[23:0]},
         40'hFF_FFFF, 2'h1);
    xfer(tsc_pkg::LEN_SEL, {tsc_pkg::CMD_SEL, SER_W, 8'h00, 27'h0}, 6'h28, 40'h00_2200_3C00, MHI, 2'h0);
    wait_st(tsc_pkg::ST_SEL);
    xfer(tsc_pkg::LEN_QUIET, {tsc_pkg::CMD_QUIET, 8'h00, 59'h0}, 6'h00, 40'h0, 40'h0, 2'h0);
    xfer(tsc_pkg::LEN_REQ, {tsc_pkg::CMD_REQ_HDR, 2'h1, 67'h0}, 6'h00, 40'h0, 40'h0, 2'h0);
    wait_st(tsc_pkg::ST_QUIET);
    field_en <= 1'b0;
    wait_st(tsc_pkg::ST_OFF);
    $display("test plain done");
  endtask : t_plain
  task automatic t_sil();
    field_en <= 1'b1;
    wait_st(tsc_pkg::ST_READY);
    xfer(tsc_pkg::LEN_REQ, {tsc_pkg::CMD_REQ_HDR, 2'h3, 67'h0}, 6'h20, {8'h00, SER_W}, M32, 2'h0);
    chk({38'h0, mode}, 40'h3);
    xfer(tsc_pkg::LEN_SEL, {tsc_pkg::CMD_SIL, SER_W, 8'h00, 27'h0}, 6'h02, 40'h1, 40'h3, 2'h0);
    wait_st(tsc_pkg::ST_QUIET);
    field_en <= 1'b0;
    wait_st(tsc_pkg::ST_OFF);
    $display("test silence done");
  endtask : t_sil
  task automatic t_auth();
    pg_wr(tsc_pkg::PG_CONFIG, 32'h5A00_0003);
    pg_wr(tsc_pkg::PG_KEY_HIGH_PASSWORD_LOW_PAGE, KP2);
    pg_wr(tsc_pkg::PG_KEY_LOW_BYTES, KP3);
    field_en <= 1'b1;
    wait_st(tsc_pkg::ST_READY);
    xfer(tsc_pkg::LEN_REQ, {tsc_pkg::CMD_REQ_HDR, 2'h0, 67'h0}, 6'h20, {8'h00, SER_W}, M32, 2'h0);
    xfer(tsc_pkg::LEN_SEL, {tsc_pkg::CMD_SEL, SER_W, 8'h00, 27'h0}, 6'h28, 40'h03_0000_FF00, MHI, 2'h2);
    wait_st(tsc_pkg::ST_AUTH);
    xfer(tsc_pkg::LEN_CHAL, {RND, RND, 8'h00}, 6'h00, 40'h0, 40'h0, 2'h0);
    wait_st(tsc_pkg::ST_AUTH);
    xfer(tsc_pkg::LEN_CHAL, {RND, RND ^ KP3, 8'h00}, 6'h28, {32'h005A_6677 ^ RND ^ KP2, 8'h00}, MHI,
         2'h0);
    wait_st(tsc_pkg::ST_SEL);
    field_en <= 1'b0;
    wait_st(tsc_pkg::ST_OFF);
    $display("test authenticate done");
  endtask : t_auth
  task automatic t_ttf();
    pg_wr(tsc_pkg::PG_CONFIG, 32'h000D_0004);
    field_en <= 1'b1;
    wait_st(tsc_pkg::ST_READY);
    wait_st(tsc_pkg::ST_TTF);
    field_en <= 1'b0;
    wait_st(tsc_pkg::ST_OFF);
    $display("test tag first done");
  endtask : t_ttf
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_plain();
    t_sil();
    t_auth();
    t_ttf();
    end_of_test();
  end
  // tests need ~11000 cycles
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    err_count++;
    end_of_test();
  end
endmodule : test_rfid_tag_state_and_command_logic
`default_nettype wire
